// file: hdl/lbc_exec.sv
`timescale 1ns/1ps
// Behaviour
// - Register AND: accumulator with register, Z
// - Dest 0 to accumulator, 1 to register
// - Immediate AND into accumulator, only Z
// - Bit clear/set, flags kept, one cycle
// - Skip next instruction when tested bit clear
// - Skip executes no-op, two cycles total
// - Call pushes PC plus one, pointer advances
// - Call jumps to table bits and accumulator
// - Table pointer high supplies upper call address
// - Register operands span 0x00 to 0x7f
module lbc_exec import lbc_pkg::*; (
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    // Instruction from fetch
    input  wire logic                instr_valid,
    input  wire lbc_op_type          instr_op,
    input  wire logic [RADDR_W-1:0]  instr_reg,
    input  wire logic [BIT_W-1:0]    instr_bit,
    input  wire logic                instr_dest,
    input  wire logic [DATA_W-1:0]   instr_imm,
    input  wire logic [PC_W-1:0]     pc_current,
    // Register file read data
    input  wire logic [DATA_W-1:0]   reg_rdata,
    input  wire logic [DATA_W-1:0]   table_ptr_high,
    // Accumulator load from the rest of the core
    input  wire logic                acc_wr,
    input  wire logic [DATA_W-1:0]   acc_wdata,
    // Register file write port
    output logic [RADDR_W-1:0]       reg_addr,
    output logic                     reg_we,
    output logic [DATA_W-1:0]        reg_wdata,
    // Core state
    output logic [DATA_W-1:0]        accumulator,
    output logic                     zero_flag,
    output logic [PC_W-1:0]          pc_load_value,
    output logic                     pc_load,
    output logic [SP_W-1:0]          stack_ptr,
    output logic [PC_W-1:0]          stack_top,
    // Pipeline control
    output logic                     busy,
    output logic                     discard_fetch
);
    // =================================================================
    // Storage
    lbc_state_type          state;              // Execution phase
    lbc_state_type          next_state;         // Next phase
    logic [PC_W-1:0]        stack_mem [STACK_DEPTH]; // Return stack
    logic [PC_W-1:0]        call_target;        // Latched call address
    logic [DATA_W-1:0]      reg_wr_q;           // Write data register

    // =================================================================
    // Decode
    wire take       = instr_valid && (state == ST_EXEC);
    wire is_andr    = take && (instr_op == OP_AND_ACC_REG);
    wire is_andi    = take && (instr_op == OP_AND_ACC_IMM);
    wire is_bclr    = take && (instr_op == OP_BIT_CLEAR_REG);
    wire is_bset    = take && (instr_op == OP_BIT_SET_REG);
    wire is_btsc    = take && (instr_op == OP_BIT_TEST_SKIP_CLEAR);
    wire is_call    = take && (instr_op == OP_CALL_BY_ACCUMULATOR);
    wire [DATA_W-1:0] bit_mask  = DATA_W'(1) << instr_bit;
    wire [DATA_W-1:0] and_reg   = accumulator & reg_rdata;
    wire [DATA_W-1:0] and_imm   = accumulator & instr_imm;
    wire [DATA_W-1:0] and_res   = is_andi ? and_imm : and_reg;
    wire              and_zero  = (and_res == ZERO_BYTE);
    wire [DATA_W-1:0] bit_res   = is_bset ? (reg_rdata | bit_mask)
                                          : (reg_rdata & ~bit_mask);
    wire              skip_take = is_btsc && !reg_rdata[instr_bit];
    wire [PC_W-1:0]   next_target = {table_ptr_high[TBH_BITS-1:0], accumulator};
    wire              reg_write = (is_andr && instr_dest) || is_bclr || is_bset;
    // An AND owns the accumulator in its cycle; an outside load then is dropped
    wire              acc_from_and = is_andi || (is_andr && !instr_dest);
    wire              acc_load     = acc_wr && !is_andi && !is_andr;

    // The register address is the full 7-bit field, so 0x00..0x7f
    assign reg_addr      = instr_reg;
    assign busy          = (state != ST_EXEC);
    assign discard_fetch = (state == ST_SKIP);
    assign pc_load       = (state == ST_CALL);
    assign pc_load_value = call_target;
    assign stack_top     = stack_mem[stack_ptr - SP_ONE];

    // =================================================================
    // Phase sequencing: skip and call each add one cycle
    always_comb begin
        next_state = ST_EXEC;
        unique case (state)
            ST_EXEC: begin
                if (skip_take) begin
                    next_state = ST_SKIP;
                end else if (is_call) begin
                    next_state = ST_CALL;
                end
            end
            ST_SKIP: next_state = ST_EXEC;
            ST_CALL: next_state = ST_EXEC;
            default: next_state = ST_EXEC;                              // Unused code falls back
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_EXEC;
        end else begin
            state <= next_state;
        end
    end

    // =================================================================
    // Accumulator and zero flag; bit ops, test and call leave Z alone
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            accumulator <= ZERO_BYTE;
            zero_flag   <= 1'b0;
        end else begin
            if (acc_from_and) begin
                accumulator <= and_res;
            end else if (acc_load) begin
                accumulator <= acc_wdata;
            end
            if (is_andi || is_andr) begin
                zero_flag <= and_zero;
            end
        end
    end

    // =================================================================
    // Register write-back, registered so data outputs come from flops
    // The write lands one cycle after the read, so the register file must hold the address
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_we   <= 1'b0;
            reg_wr_q <= ZERO_BYTE;
        end else begin
            reg_we   <= reg_write;
            reg_wr_q <= is_andr ? and_reg : bit_res;
        end
    end
    assign reg_wdata = reg_wr_q;

    // =================================================================
    // Return stack push; wraps silently when full, as a hardware stack does
    // Eight nested calls fill it; a ninth overwrites the oldest return address
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stack_ptr   <= '0;
            call_target <= PC_RESET;
            for (int i = 0; i < STACK_DEPTH; i++) begin
                stack_mem[i] <= PC_RESET;
            end
        end else if (is_call) begin
            stack_mem[stack_ptr] <= pc_current + PC_ONE;
            stack_ptr            <= stack_ptr + SP_ONE;
            call_target          <= next_target;
        end
    end

    // =================================================================
    // Checks
    sequence s_call_req;
        is_call;
    endsequence
    sequence s_call_done;
        pc_load && (pc_load_value == $past(next_target)) ##1 !busy;
    endsequence

    // AND results, destinations and zero flag
    AST_AND_REG_Z: assert property (@(posedge core_clk) disable iff (!rst_n)
        is_andr |=> zero_flag == ($past(and_reg) == ZERO_BYTE))
        else $error("register AND zero flag wrong");
    AST_DEST_ACC: assert property (@(posedge core_clk) disable iff (!rst_n)
        (is_andr && !instr_dest) |=> accumulator == $past(and_reg) && !reg_we)
        else $error("AND to accumulator wrong");
    AST_DEST_REG: assert property (@(posedge core_clk) disable iff (!rst_n)
        (is_andr && instr_dest) |=> reg_we && reg_wdata == $past(and_reg)
            && $stable(accumulator))
        else $error("AND to register wrong");
    AST_AND_IMM: assert property (@(posedge core_clk) disable iff (!rst_n)
        is_andi |=> accumulator == $past(and_imm) && !reg_we)
        else $error("immediate AND wrong");
    AST_IMM_Z: assert property (@(posedge core_clk) disable iff (!rst_n)
        is_andi |=> zero_flag == ($past(and_imm) == ZERO_BYTE))
        else $error("immediate AND zero flag wrong");

    // Bit operations and the skip
    AST_BIT_OPS: assert property (@(posedge core_clk) disable iff (!rst_n)
        (is_bclr || is_bset) |=> reg_we && $stable(zero_flag) && !busy
            && reg_wdata == $past(bit_res))
        else $error("bit clear or set wrong");
    AST_SKIP: assert property (@(posedge core_clk) disable iff (!rst_n)
        (is_btsc && !reg_rdata[instr_bit]) |=> discard_fetch && $stable(zero_flag))
        else $error("skip not taken");
    AST_NO_SKIP: assert property (@(posedge core_clk) disable iff (!rst_n)
        (is_btsc && reg_rdata[instr_bit]) |=> !discard_fetch)
        else $error("skip taken on set bit");
    AST_SKIP_LEN: assert property (@(posedge core_clk) disable iff (!rst_n)
        discard_fetch |=> !busy)
        else $error("skip longer than two cycles");
    AST_TEST_NO_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
        is_btsc |=> !reg_we && $stable(zero_flag))
        else $error("bit test wrote or changed Z");

    // Call and return stack
    AST_PUSH: assert property (@(posedge core_clk) disable iff (!rst_n)
        is_call |=> stack_ptr == $past(stack_ptr) + SP_ONE
            && stack_top == $past(pc_current) + PC_ONE)
        else $error("call push wrong");
    AST_CALL: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_call_req |=> s_call_done)
        else $error("call target or length wrong");
    AST_CALL_FLAGS: assert property (@(posedge core_clk) disable iff (!rst_n)
        is_call |=> $stable(zero_flag) && !reg_we)
        else $error("call changed Z or wrote a register");

    // Outside accumulator load
    AST_ACC_LOAD: assert property (@(posedge core_clk) disable iff (!rst_n)
        acc_load |=> accumulator == $past(acc_wdata))
        else $error("outside accumulator load lost");
endmodule

// file: hdl/lbc_pkg.sv
// =====================================================================
// Shared constants and types for the logic, bit and call executor
package lbc_pkg;
    localparam int DATA_W      = 8;      // Accumulator and register width
    localparam int RADDR_W     = 7;      // Register address 0x00..0x7f
    localparam int BIT_W       = 3;      // Bit select 0..7
    localparam int PC_W        = 11;     // Program counter width
    localparam int SP_W        = 3;      // Stack pointer width
    localparam int STACK_DEPTH = 8;      // Hardware stack entries
    localparam int PCH_LSB     = 8;      // Low bit of the upper PC field
    localparam int TBH_BITS    = 3;      // Table pointer bits used for the call
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [PC_W-1:0]   PC_ONE    = 11'h001;
    localparam logic [SP_W-1:0]   SP_ONE    = 3'h1;
    localparam logic [PC_W-1:0]   PC_RESET  = 11'h000;

    // Operation selects from the fetch stage
    typedef enum logic [2:0] {
        OP_NONE, OP_AND_ACC_REG, OP_AND_ACC_IMM, OP_BIT_CLEAR_REG,
        OP_BIT_SET_REG, OP_BIT_TEST_SKIP_CLEAR, OP_CALL_BY_ACCUMULATOR
    } lbc_op_type;

    // Execution phase
    typedef enum logic [1:0] {ST_EXEC, ST_SKIP, ST_CALL} lbc_state_type;
endpackage

// file: testbench/lbc_exec_tb.sv
`timescale 1ns/1ps
module lbc_exec_tb import lbc_pkg::*;;
    // ==========================================================
    // Stimulus and observed signals
    logic               core_clk;        // 20 MHz core clock
    logic               rst_n;           // Async reset, active low
    logic               instr_valid;     // Instruction present
    lbc_op_type         instr_op;        // Operation select
    logic [RADDR_W-1:0] instr_reg;       // Register operand
    logic [BIT_W-1:0]   instr_bit;       // Bit operand
    logic               instr_dest;      // Destination select
    logic [DATA_W-1:0]  instr_imm;       // Immediate operand
    logic [PC_W-1:0]    pc_current;      // Current instruction address
    logic [DATA_W-1:0]  reg_rdata;       // Register read data
    logic [DATA_W-1:0]  table_ptr_high;  // Upper call address source
    logic               acc_wr;          // Outside accumulator load
    logic [DATA_W-1:0]  acc_wdata;       // Outside accumulator value
    logic [RADDR_W-1:0] reg_addr;
    logic               reg_we;
    logic [DATA_W-1:0]  reg_wdata;
    logic [DATA_W-1:0]  accumulator;
    logic               zero_flag;
    logic [PC_W-1:0]    pc_load_value;
    logic               pc_load;
    logic [SP_W-1:0]    stack_ptr;
    logic [PC_W-1:0]    stack_top;
    logic               busy;
    logic               discard_fetch;
    int                 errors;          // Mismatch count
    int                 comparisons;     // Comparison count

    lbc_exec uut (.core_clk(core_clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr_op(instr_op),
        .instr_reg(instr_reg), .instr_bit(instr_bit), .instr_dest(instr_dest), .instr_imm(instr_imm),
        .pc_current(pc_current), .reg_rdata(reg_rdata), .table_ptr_high(table_ptr_high),
        .acc_wr(acc_wr), .acc_wdata(acc_wdata),
        .reg_addr(reg_addr), .reg_we(reg_we), .reg_wdata(reg_wdata), .accumulator(accumulator),
        .zero_flag(zero_flag), .pc_load_value(pc_load_value), .pc_load(pc_load), .stack_ptr(stack_ptr),
        .stack_top(stack_top), .busy(busy), .discard_fetch(discard_fetch));

    // ==========================================================
    // Clock, 50 ns period
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // ==========================================================
    // Compare and closing tasks
    task automatic check_val(input string name, input logic [PC_W-1:0] exp, input logic [PC_W-1:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_bit(input string name, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic end_of_test();
        if (errors == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // One instruction: launched at one edge, taken at the next, results looked at just after it
    task automatic issue(input lbc_op_type op, input logic [6:0] r, input logic [2:0] b, input logic d,
                         input logic [7:0] data);
        @(posedge core_clk);
        instr_valid <= 1'b1;
        instr_op    <= op;
        instr_reg   <= r;
        instr_bit   <= b;
        instr_dest  <= d;
        reg_rdata   <= data;
        instr_imm   <= data;
        @(posedge core_clk);
        instr_valid <= 1'b0;
        #1;
    endtask

    // ==========================================================
    // Scenarios; the accumulator is preloaded through its outside write port
    task automatic load_acc(input logic [7:0] value);
        @(posedge core_clk);
        acc_wr    <= 1'b1;
        acc_wdata <= value;
        @(posedge core_clk);
        acc_wr    <= 1'b0;
        #1;
    endtask

    task automatic test_and();
        load_acc(8'h5a);
        issue(OP_AND_ACC_IMM, 7'h05, 3'h0, 1'b1, 8'ha5);             // Immediate ignores dest
        check_bit("imm_we", 1'b0, reg_we);
        check_val("imm_acc", 11'h000, {3'h0, accumulator});
        check_bit("imm_zero", 1'b1, zero_flag);
        load_acc(8'h5a);
        issue(OP_AND_ACC_REG, 7'h7f, 3'h0, 1'b1, 8'haf);             // Top register, result written back
        check_bit("reg_we", 1'b1, reg_we);
        check_val("reg_addr", 11'h07f, {4'h0, reg_addr});
        check_val("reg_wdata", 11'h00a, {3'h0, reg_wdata});
        check_val("acc_kept", 11'h05a, {3'h0, accumulator});
        check_bit("zero_flag", 1'b0, zero_flag);
        issue(OP_AND_ACC_REG, 7'h05, 3'h0, 1'b0, 8'ha5);             // Result to accumulator only
        check_bit("acc_we", 1'b0, reg_we);
        check_val("accumulator", 11'h000, {3'h0, accumulator});
        check_bit("zero_set", 1'b1, zero_flag);
    endtask

    task automatic test_bits();
        issue(OP_BIT_CLEAR_REG, 7'h10, 3'h3, 1'b0, 8'h5a);
        check_val("clear_wdata", 11'h052, {3'h0, reg_wdata});
        check_bit("clear_we", 1'b1, reg_we);
        check_bit("clear_busy", 1'b0, busy);
        issue(OP_BIT_SET_REG, 7'h10, 3'h2, 1'b0, 8'h5a);             // One idle cycle after the clear
        check_val("set_wdata", 11'h05e, {3'h0, reg_wdata});
        check_bit("set_zero", 1'b1, zero_flag);
    endtask

    task automatic test_skip();
        issue(OP_BIT_TEST_SKIP_CLEAR, 7'h11, 3'h2, 1'b0, 8'h5a);     // Bit 2 is clear
        check_bit("discard", 1'b1, discard_fetch);
        check_bit("skip_busy", 1'b1, busy);
        @(posedge core_clk);
        #1;
        check_bit("discard_end", 1'b0, discard_fetch);
        check_bit("skip_free", 1'b0, busy);
        issue(OP_BIT_TEST_SKIP_CLEAR, 7'h11, 3'h1, 1'b0, 8'h5a);     // Bit 1 is set
        check_bit("no_discard", 1'b0, discard_fetch);
        check_bit("no_busy", 1'b0, busy);
        check_bit("skip_zero", 1'b1, zero_flag);
    endtask

    task automatic test_call();
        @(posedge core_clk);
        table_ptr_high <= 8'hfa;                                     // Only the low three bits matter
        pc_current     <= 11'h0a0;
        load_acc(8'h34);
        issue(OP_CALL_BY_ACCUMULATOR, 7'h00, 3'h0, 1'b0, 8'h00);
        check_val("stack_ptr", 11'h001, {8'h0, stack_ptr});
        check_val("stack_top", 11'h0a1, stack_top);
        check_bit("pc_load", 1'b1, pc_load);
        check_val("pc_load_value", 11'h234, pc_load_value);
        check_bit("call_busy", 1'b1, busy);
        @(posedge core_clk);
        #1;
        check_bit("pc_load_end", 1'b0, pc_load);
        check_bit("call_free", 1'b0, busy);
        check_bit("call_zero", 1'b1, zero_flag);
    endtask

    // ==========================================================
    // Main sequence; inputs all defined at time zero
    initial begin
        errors = 0;
        comparisons = 0;
        rst_n = 1'b0;
        {instr_valid, instr_dest, instr_reg, instr_bit, instr_imm, reg_rdata, acc_wr, acc_wdata} = '0;
        instr_op = OP_NONE;
        pc_current = 11'h000;
        table_ptr_high = 8'h00;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        test_and();
        test_bits();
        test_skip();
        test_call();
        end_of_test();
    end

    // Watchdog: the run needs well under 100 cycles, so 2000 means a hang
    initial begin
        #(50 * 2000);
        errors++;
        end_of_test();
    end
endmodule
